// file: hw/inhibit_io_defs.svh
// register offsets, field positions, reset values and timing counts for the inhibit pin block
`ifndef INHIBIT_IO_DEFS_SVH
`define INHIBIT_IO_DEFS_SVH

`define IOP_CTRL_OFS        12'h000
`define IOP_CMD_OFS         12'h004
`define IOP_STATUS_OFS      12'h008
`define IOP_PWM_PERIOD_OFS  12'h00c
`define IOP_PWM_DUTY_OFS    12'h010

`define IOP_CTRL_FUNC_LSB   0
`define IOP_CTRL_LATCH_BIT  2
`define IOP_CTRL_INV_BIT    3
`define IOP_CTRL_OUT_LSB    4

`define IOP_CMD_ON_BIT      0
`define IOP_CMD_OFF_BIT     1
`define IOP_CMD_CLRPROT_BIT 2

`define IOP_CTRL_RESET      32'h0000_0000
`define IOP_PWM_PERIOD_RST  32'h0000_03e8
`define IOP_PWM_DUTY_RST    32'h0000_01f4

`define IOP_MIN_LOW_US      30
`define IOP_CLK_MHZ         100
`define IOP_MIN_LOW_CYC     (`IOP_MIN_LOW_US * `IOP_CLK_MHZ)

`endif

// file: hw/inhibit_io_pkg.sv
// types for the inhibit pin block
package inhibit_io_pkg;

    typedef enum logic [1:0]
    {
        FUNC_INHIBIT = 2'b00,
        FUNC_INPUT   = 2'b01,
        FUNC_OUTPUT  = 2'b10
    } pin_func_t;

    typedef enum logic [1:0]
    {
        OUT_ONE  = 2'b00,
        OUT_ZERO = 2'b01,
        OUT_PWM  = 2'b10
    } out_sel_t;

    typedef struct packed
    {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed
    {
        logic        inputOn;
        logic        inputActive;
        logic        inhibitActiveFlag;
        logic        latchedInhibitProtection;
        logic        levelValue;
    } pin_status_t;

endpackage

// file: hw/pwm_gen.sv
// period/duty pulse generator for the pin output function
module pwm_gen
#(
    parameter int WIDTH = 32
)
(
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] period,
    input  wire logic [WIDTH-1:0] duty,
    output logic                  pwmOut
);

    logic [WIDTH-1:0] count;

    // period sets frequency, duty the high count
    always_ff @(posedge mclk)
    begin
        if (reset || !enable)
            count <= '0;
        else if (count + 1'b1 >= period)
            count <= '0;
        else
            count <= count + 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset || !enable)
            pwmOut <= 1'b0;
        else
            pwmOut <= (count < duty);
    end

endmodule // pwm_gen

// file: hw/inhibit_io_pin.sv
// inhibit / level input / digital output control for one rear I/O pin
`include "inhibit_io_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module inhibit_io_pin
#(
    parameter int MIN_LOW_CYC = `IOP_MIN_LOW_CYC
)
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pinIn,
    output logic             pinOut,
    output logic             pinOe,
    output logic             inputActive,
    output logic             inputOn,
    output logic             inhibitActiveFlag,
    output logic             latchedInhibitProtection
);

    ////////////////////////////////////////////////////////////////////////////
    // register bus
    inhibit_io_pkg::apb_req_t req;
    logic [31:0]              ctrl;
    logic [31:0]              pwmPeriod;
    logic [31:0]              pwmDuty;
    logic                     acc;
    logic                     wrAcc;
    logic                     cmdWr;
    logic                     mapped;
    logic [31:0]              next_prdata;

    assign req   = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};
    assign acc   = req.psel && req.penable && pready;
    assign wrAcc = acc && req.pwrite;
    assign cmdWr = wrAcc && (req.paddr == `IOP_CMD_OFS);

    assign mapped = (req.paddr == `IOP_CTRL_OFS) || (req.paddr == `IOP_CMD_OFS)
                 || (req.paddr == `IOP_STATUS_OFS) || (req.paddr == `IOP_PWM_PERIOD_OFS)
                 || (req.paddr == `IOP_PWM_DUTY_OFS);

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge mclk)
    begin
        if (reset)
            pready <= 1'b0;
        else
            pready <= req.psel && req.penable && !pready;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            pslverr <= 1'b0;
        else
            pslverr <= req.psel && req.penable && !pready && !mapped;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ctrl      <= `IOP_CTRL_RESET;
            pwmPeriod <= `IOP_PWM_PERIOD_RST;
            pwmDuty   <= `IOP_PWM_DUTY_RST;
        end
        else if (wrAcc)
        begin
            if (req.paddr == `IOP_CTRL_OFS)
                ctrl <= req.pwdata & 32'h0000_003f;
            if (req.paddr == `IOP_PWM_PERIOD_OFS)
                pwmPeriod <= req.pwdata;
            if (req.paddr == `IOP_PWM_DUTY_OFS)
                pwmDuty <= req.pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control fields
    inhibit_io_pkg::pin_func_t func;
    inhibit_io_pkg::out_sel_t  outSel;
    logic                      latchMode;
    logic                      invert;

    assign func      = inhibit_io_pkg::pin_func_t'(ctrl[`IOP_CTRL_FUNC_LSB +: 2]);
    assign latchMode = ctrl[`IOP_CTRL_LATCH_BIT];
    assign invert    = ctrl[`IOP_CTRL_INV_BIT];
    assign outSel    = inhibit_io_pkg::out_sel_t'(ctrl[`IOP_CTRL_OUT_LSB +: 2]);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser: stage one feeds stage two only
    logic syncA;
    logic syncB;
    logic pinPrev;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            syncA <= 1'b1; // floating pin reads high
            syncB <= 1'b1;
        end
        else
        begin
            syncA <= pinIn;
            syncB <= syncA;
        end
    end

    // asserted = low when not inverted, high when inverted
    logic pinAsserted;
    assign pinAsserted = syncB ^ ~invert;

    always_ff @(posedge mclk)
    begin
        if (reset)
            pinPrev <= 1'b0;
        else
            pinPrev <= pinAsserted;
    end

    ////////////////////////////////////////////////////////////////////////////
    // latch pulse qualification: count asserted width from its leading edge
    logic [31:0] lowCount;
    logic        armed;
    logic        pulseHit;

    always_ff @(posedge mclk)
    begin
        if (reset || !pinAsserted)
            lowCount <= '0;
        else if (lowCount < 32'(MIN_LOW_CYC))
            lowCount <= lowCount + 32'h0000_0001;
    end

    // armed by the leading edge, fires once when the minimum width is met
    always_ff @(posedge mclk)
    begin
        if (reset || !pinAsserted)
            armed <= 1'b0;
        else if (pinAsserted && !pinPrev)
            armed <= 1'b1;
        else if (pulseHit)
            armed <= 1'b0;
    end

    // pin still asserted in the counting cycle, else a pulse one cycle short would pass
    assign pulseHit = armed && pinAsserted && (lowCount == 32'(MIN_LOW_CYC) - 32'h0000_0001);

    ////////////////////////////////////////////////////////////////////////////
    // input on/off state and protection
    logic latchTrip;
    logic offCmd;
    assign latchTrip = (func == inhibit_io_pkg::FUNC_INHIBIT) && latchMode && pulseHit
                    && inputOn && !latchedInhibitProtection;
    assign offCmd    = cmdWr && req.pwdata[`IOP_CMD_OFF_BIT];

    always_ff @(posedge mclk)
    begin
        if (reset)
            inputOn <= 1'b0;
        else if (latchTrip)
            inputOn <= 1'b0; // trip beats a same-cycle turn-on
        else if (offCmd)
            inputOn <= 1'b0;
        else if (cmdWr && req.pwdata[`IOP_CMD_ON_BIT] && !latchedInhibitProtection)
            inputOn <= 1'b1; // only by operator command
    end

    // set wins over a same-cycle clear
    always_ff @(posedge mclk)
    begin
        if (reset)
            latchedInhibitProtection <= 1'b0;
        else if (latchTrip)
            latchedInhibitProtection <= 1'b1;
        else if (cmdWr && req.pwdata[`IOP_CMD_CLRPROT_BIT])
            latchedInhibitProtection <= 1'b0;
    end

    logic next_inhibit;
    assign next_inhibit = (func == inhibit_io_pkg::FUNC_INHIBIT) && !latchMode && pinAsserted;

    // level follow: suppress while asserted, recover by itself
    always_ff @(posedge mclk)
    begin
        if (reset)
            inhibitActiveFlag <= 1'b0;
        else
            inhibitActiveFlag <= next_inhibit && inputOn && !offCmd;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            inputActive <= 1'b0;
        else
            // off command drops both with inputOn, so neither outlives the on state
            inputActive <= inputOn && !latchTrip && !offCmd && !next_inhibit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // output function
    logic pwmWave;
    logic outLogic;

    pwm_gen #(.WIDTH(32)) pwm
    (
        .mclk   (mclk),
        .reset  (reset),
        .enable (func == inhibit_io_pkg::FUNC_OUTPUT && outSel == inhibit_io_pkg::OUT_PWM),
        .period (pwmPeriod),
        .duty   (pwmDuty),
        .pwmOut (pwmWave)
    );

    always_comb
    begin
        unique case (outSel)
            inhibit_io_pkg::OUT_ONE:  outLogic = 1'b1;
            inhibit_io_pkg::OUT_ZERO: outLogic = 1'b0;
            inhibit_io_pkg::OUT_PWM:  outLogic = pwmWave;
            default:                  outLogic = 1'b0;
        endcase
    end

    // logic 1 drives low unless inverted
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pinOut <= 1'b1;
            pinOe  <= 1'b0;
        end
        else
        begin
            pinOut <= outLogic ^ ~invert;
            pinOe  <= (func == inhibit_io_pkg::FUNC_OUTPUT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data
    inhibit_io_pkg::pin_status_t st;
    assign st = '{inputOn: inputOn, inputActive: inputActive, inhibitActiveFlag: inhibitActiveFlag,
                  latchedInhibitProtection: latchedInhibitProtection,
                  levelValue: (func == inhibit_io_pkg::FUNC_INPUT) ? pinAsserted : 1'b0};

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (req.paddr == `IOP_CTRL_OFS)
            next_prdata = ctrl;
        else if (req.paddr == `IOP_STATUS_OFS)
            next_prdata = {27'h000_0000, st};
        else if (req.paddr == `IOP_PWM_PERIOD_OFS)
            next_prdata = pwmPeriod;
        else if (req.paddr == `IOP_PWM_DUTY_OFS)
            next_prdata = pwmDuty;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (req.psel && req.penable && !pready && !req.pwrite)
            prdata <= next_prdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_trip;
        latchTrip;
    endsequence

    a_trip_offs: assert property (@(posedge mclk) disable iff (reset)
        s_trip |=> !inputOn && latchedInhibitProtection) else $error("latch trip did not switch off");
    a_prot_blocks: assert property (@(posedge mclk) disable iff (reset)
        latchedInhibitProtection && !inputOn |=> !inputOn) else $error("turn-on while protected");
    a_level_inh: assert property (@(posedge mclk) disable iff (reset)
        inhibitActiveFlag |-> !inputActive && inputOn) else $error("inhibit did not suppress input");
    a_level_rec: assert property (@(posedge mclk) disable iff (reset)
        inputOn && !next_inhibit && !latchTrip && !(cmdWr && pwdata[`IOP_CMD_OFF_BIT]) |=> inputActive)
        else $error("input did not recover");
    a_inh_flag: assert property (@(posedge mclk) disable iff (reset)
        next_inhibit && inputOn && !offCmd |=> inhibitActiveFlag) else $error("inhibit flag missing");
    a_pulse_width: assert property (@(posedge mclk) disable iff (reset)
        pulseHit |-> pinAsserted && $past(pinAsserted) && lowCount == 32'(MIN_LOW_CYC) - 32'h0000_0001)
        else $error("short pulse accepted");
    a_out_level: assert property (@(posedge mclk) disable iff (reset)
        func == inhibit_io_pkg::FUNC_OUTPUT && outSel == inhibit_io_pkg::OUT_ONE && !invert
        && $stable(ctrl) |=> pinOe && !pinOut) else $error("logic one not driven low");
    a_sync_lat: assert property (@(posedge mclk) disable iff (reset)
        syncB == $past(pinIn, 2) || $past(reset, 2)) else $error("synchroniser depth wrong");

endmodule // inhibit_io_pin

// file: tb/pin_source.sv
// external equipment model driving the inhibit pin
module pin_source
(
    input  wire logic mclk,
    input  wire logic pinOut,
    input  wire logic pinOe,
    output logic      pinIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic driven = 1'b0;
    logic level  = 1'b1;
    // an undriven pin is pulled up, so release reads high
    assign pinIn = pinOe ? pinOut : (driven ? level : 1'b1);
    task automatic drive(input logic l);
        @(posedge mclk);
        driven <= 1'b1;
        level  <= l;
    endtask
    task automatic release_pin();
        @(posedge mclk);
        driven <= 1'b0;
    endtask
    // asserted phase held for the full width, never cut short
    task automatic pulse(input logic act, input int width);
        drive(act);
        repeat (width) @(posedge mclk);
        drive(!act);
    endtask
endmodule // pin_source

// file: tb/inhibit_io_pin_bench.sv
// self-checking bench for the inhibit pin control block
`include "inhibit_io_defs.svh"
module inhibit_io_pin_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // short qualify time keeps latch tests brief
    localparam int MINLOW = 20;
    localparam logic [11:0] CTRL = `IOP_CTRL_OFS;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, pinIn, pinOut, pinOe;
    logic        inputActive, inputOn, inhibitActiveFlag, latchedInhibitProtection;
    logic [33:0] notes[$];
    logic [31:0] seed = 32'h419c_d1bc;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    int          highs;

    always #5 mclk = ~mclk;

    inhibit_io_pin #(.MIN_LOW_CYC(MINLOW)) u_dut
    (
        .mclk(mclk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .inputActive(inputActive), .inputOn(inputOn), .inhibitActiveFlag(inhibitActiveFlag),
        .latchedInhibitProtection(latchedInhibitProtection)
    );
    pin_source u_src (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic print_verdict();
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // note holds {read, slverr, data}; write data is not compared
    task automatic cmp_bus(input logic [33:0] exp);
        checked++;
        if (pslverr !== exp[32] || (exp[33] && prdata !== exp[31:0]))
        begin
            mismatches++;
            $display("ERROR %0t: bus %h/%b want %h/%b", $time, prdata, pslverr, exp[31:0], exp[32]);
        end
    endtask

    always @(negedge mclk)
        if (psel && penable && pready === 1'b1)
            cmp_bus(notes.pop_front());

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////
    // request held until pready is seen high at a falling edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic err);
        @(posedge mclk);
        notes.push_back({!w, err, w ? 32'h0000_0000 : d});
        paddr  <= a;
        pwrite <= w;
        pwdata <= w ? d : 32'h0000_0000;
        psel   <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(negedge mclk);
        while (pready !== 1'b1);
        @(posedge mclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ctl(input logic [5:0] v);
        apb(CTRL, 1'b1, {26'h000_0000, v}, 1'b0);
    endtask

    task automatic cmd(input logic [2:0] c);
        apb(`IOP_CMD_OFS, 1'b1, {29'h0000_0000, c}, 1'b0);
    endtask

    // random wait, always past the synchroniser latency
    task automatic settle();
        seed = xs(seed);
        repeat (8 + seed[2:0]) @(posedge mclk);
    endtask

    task automatic chk(input inhibit_io_pkg::pin_status_t s);
        @(negedge mclk);
        cmp_val({28'h000_0000, inputOn, inputActive, inhibitActiveFlag, latchedInhibitProtection},
                {28'h000_0000, s[4:1]}, "status pins");
        apb(`IOP_STATUS_OFS, 1'b0, {27'h000_0000, s}, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        apb(CTRL, 1'b0, `IOP_CTRL_RESET, 1'b0);
        apb(`IOP_PWM_PERIOD_OFS, 1'b0, `IOP_PWM_PERIOD_RST, 1'b0);
        apb(`IOP_PWM_DUTY_OFS, 1'b0, `IOP_PWM_DUTY_RST, 1'b0);
        apb(12'h100, 1'b0, 32'h0000_0000, 1'b1);
        apb(12'h100, 1'b1, 32'h0000_0005, 1'b1);
        chk(5'b00000);
        cmd(3'h1);
        settle();
        chk(5'b11000);
        for (int inv = 0; inv < 2; inv++)
        begin
            ctl(inv ? 6'h08 : 6'h00);
            u_src.drive(inv[0]);
            settle();
            chk(5'b10100);
            cmd(3'h2);
            chk(5'b00000);
            cmd(3'h1);
            u_src.drive(!inv[0]);
            settle();
            chk(5'b11000);
        end
        for (int inv = 0; inv < 2; inv++)
        begin
            // park in input function so the mode switch sees no edge
            ctl(6'h01);
            u_src.drive(!inv[0]);
            settle();
            ctl(inv ? 6'h0c : 6'h04);
            cmd(3'h1);
            settle();
            chk(5'b11000);
            // one cycle short of the minimum must not trip
            u_src.pulse(inv[0], MINLOW - 2);
            settle();
            chk(5'b11000);
            u_src.pulse(inv[0], MINLOW + 2);
            settle();
            chk(5'b00010);
            cmd(3'h1);
            chk(5'b00010);
            u_src.pulse(inv[0], MINLOW + 2);
            cmd(3'h4);
            settle();
            chk(5'b00000);
            cmd(3'h1);
            settle();
            chk(5'b11000);
        end
        for (int inv = 0; inv < 2; inv++)
            for (int lvl = 0; lvl < 2; lvl++)
            begin
                ctl(inv ? 6'h09 : 6'h01);
                u_src.drive(lvl[0]);
                settle();
                chk({4'b1100, lvl == inv});
            end
        u_src.release_pin();
        for (int k = 0; k < 4; k++)
        begin
            ctl({1'b0, k[0], k[1], 3'b010});
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            cmp_val({30'h0000_0000, pinOe, pinOut}, {30'h0000_0000, 1'b1, k[0] ^ k[1]}, "pin");
        end
        apb(`IOP_PWM_PERIOD_OFS, 1'b1, 32'h0000_000a, 1'b0);
        ctl(6'h2a);
        for (int j = 0; j < 2; j++)
        begin
            seed = xs(seed);
            apb(`IOP_PWM_DUTY_OFS, 1'b1, {29'h0000_0000, seed[2:0]} + 32'h0000_0001, 1'b0);
            repeat (30) @(posedge mclk);
            highs = 0;
            repeat (40)
            begin
                @(negedge mclk);
                highs += (pinOut === 1'b1);
            end
            cmp_val(highs, 4 * (1 + seed[2:0]), "pwm highs");
        end
        @(posedge mclk);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        cmp_val({31'h0000_0000, pinOe}, 32'h0000_0000, "oe after reset");
        chk(5'b00000);
        print_verdict();
    end
endmodule // inhibit_io_pin_bench
